// File: inc/scsr_regs.vh
// Constants for the serial configuration and pulse generator block
`ifndef SCSR_REGS_VH
`define SCSR_REGS_VH

`define SCSR_FRAME_BITS      24
`define SCSR_FRAME_CNT_W     5
`define SCSR_FRAME_DONE      5'h18
`define SCSR_ADDR_DONE       5'h08
`define SCSR_RW_BIT          23
`define SCSR_ADDR_HI         22
`define SCSR_ADDR_LO         16
`define SCSR_DATA_HI         15
`define SCSR_RW_READ         1'b1
`define SCSR_RW_WRITE        1'b0
`define SCSR_NUM_REGS        128
`define SCSR_LAST_ADDR       7'h72

// Register addresses
`define SCSR_A_MAIN_CONTROL        7'h00
`define SCSR_A_OUT_PIN_CAL_CLK     7'h01
`define SCSR_A_VCO_FORCE           7'h08
`define SCSR_A_REF_DOUBLER         7'h09
`define SCSR_A_REF_POST_DIV        7'h0b
`define SCSR_A_REF_PRE_DIV         7'h0c
`define SCSR_A_CP_GAIN             7'h0e
`define SCSR_A_VCO_BIAS            7'h10
`define SCSR_A_VCO_CAP             7'h13
`define SCSR_A_VCO_CORE            7'h14
`define SCSR_A_DIV_SEG_EN          7'h1f
`define SCSR_A_FB_DIV_HIGH         7'h22
`define SCSR_A_FB_DIV_LOW          7'h24
`define SCSR_A_DET_DELAY           7'h25
`define SCSR_A_FRAC_DEN_HIGH       7'h26
`define SCSR_A_FRAC_DEN_LOW        7'h27
`define SCSR_A_FRAC_NUM_HIGH       7'h2a
`define SCSR_A_FRAC_NUM_LOW        7'h2b
`define SCSR_A_OUT_PWR_MOD         7'h2c
`define SCSR_A_OUT_A_SEL           7'h2d
`define SCSR_A_OUT_B_SEL           7'h2e
`define SCSR_A_SYNC_PIN_IGNORE     7'h3a
`define SCSR_A_LOCK_TYPE           7'h3b
`define SCSR_A_LOCK_DELAY          7'h3c
`define SCSR_A_MOD_RST_CNT_LOW     7'h46
`define SCSR_A_PULSE_GEN_CTRL      7'h47
`define SCSR_A_PULSE_RATE_DIV      7'h48
`define SCSR_A_DELAY_WEIGHTS_12    7'h49
`define SCSR_A_DELAY_WEIGHTS_34    7'h4a

// Reset values
`define SCSR_R_MAIN_CONTROL        16'h200c
`define SCSR_R_OUT_PIN_CAL_CLK     16'h080c
`define SCSR_R_VCO_FORCE           16'h2000
`define SCSR_R_REF_DOUBLER         16'h0604
`define SCSR_R_REF_POST_DIV        16'h0018
`define SCSR_R_REF_PRE_DIV         16'h5001
`define SCSR_R_CP_GAIN             16'h1e70
`define SCSR_R_VCO_BIAS            16'h0080
`define SCSR_R_VCO_CAP             16'h27b7
`define SCSR_R_VCO_CORE            16'h3048
`define SCSR_R_DIV_SEG_EN          16'hc3ec
`define SCSR_R_FB_DIV_HIGH         16'h0010
`define SCSR_R_FB_DIV_LOW          16'h0070
`define SCSR_R_DET_DELAY           16'h0205
`define SCSR_R_FRAC_DEN            16'hffff
`define SCSR_R_OUT_PWR_MOD         16'h22a2
`define SCSR_R_OUT_A_SEL           16'hc622
`define SCSR_R_OUT_B_SEL           16'h07f0
`define SCSR_R_SYNC_PIN_IGNORE     16'h8001
`define SCSR_R_LOCK_TYPE           16'h0001
`define SCSR_R_LOCK_DELAY          16'h03e8
`define SCSR_R_MOD_RST_CNT_LOW     16'hc350
`define SCSR_R_PULSE_GEN_CTRL      16'h0080
`define SCSR_R_PULSE_RATE_DIV      16'h0001
`define SCSR_R_DELAY_WEIGHTS_12    16'h003f
`define SCSR_R_DELAY_WEIGHTS_34    16'h4000
`define SCSR_R_ZERO                16'h0000

// Main control fields
`define SCSR_F_PHASE_SYNC          14
`define SCSR_F_CAL_TRIGGER         3
`define SCSR_F_SOFT_RESET          1
`define SCSR_F_POWER_OFF           0

// Output B source field
`define SCSR_F_OUTB_SRC_HI         1
`define SCSR_OUTB_SRC_PULSE        2'h2

// Pulse generator control fields
`define SCSR_F_PREDIV_HI           7
`define SCSR_F_PREDIV_LO           5
`define SCSR_F_BURST_SELECT        4
`define SCSR_F_PULSE_GEN_ENABLE    3
`define SCSR_F_REPEAT_SELECT       2
`define SCSR_PREDIV_1              3'h1
`define SCSR_PREDIV_2              3'h2
`define SCSR_PREDIV_4              3'h4

// Rate divider and burst count fields
`define SCSR_F_RATE_DIV_HI         10
`define SCSR_RATE_BASE             12'h004
`define SCSR_F_BURST_CNT_HI        15
`define SCSR_F_BURST_CNT_LO        12

`endif

// File: logic/scsr_top.v
// Serial configuration register bank with pulse generator control
`include "scsr_regs.vh"
`default_nettype none

module scsr_top (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        sclk,
  input  wire        sdi,
  input  wire        cs_n,
  input  wire        pulse_request_pin,
  output reg         sdo,
  output reg         output_b,
  output reg         power_off,
  output reg         phase_sync_enable,
  output reg         pulse_mode_active,
  output reg         sync_pulse,
  output reg         vco_cal_trigger
);

  function [15:0] reset_value;
    input [6:0] addr;
    begin
      case (addr)
        `SCSR_A_MAIN_CONTROL:     reset_value = `SCSR_R_MAIN_CONTROL;
        `SCSR_A_OUT_PIN_CAL_CLK:  reset_value = `SCSR_R_OUT_PIN_CAL_CLK;
        `SCSR_A_VCO_FORCE:        reset_value = `SCSR_R_VCO_FORCE;
        `SCSR_A_REF_DOUBLER:      reset_value = `SCSR_R_REF_DOUBLER;
        `SCSR_A_REF_POST_DIV:     reset_value = `SCSR_R_REF_POST_DIV;
        `SCSR_A_REF_PRE_DIV:      reset_value = `SCSR_R_REF_PRE_DIV;
        `SCSR_A_CP_GAIN:          reset_value = `SCSR_R_CP_GAIN;
        `SCSR_A_VCO_BIAS:         reset_value = `SCSR_R_VCO_BIAS;
        `SCSR_A_VCO_CAP:          reset_value = `SCSR_R_VCO_CAP;
        `SCSR_A_VCO_CORE:         reset_value = `SCSR_R_VCO_CORE;
        `SCSR_A_DIV_SEG_EN:       reset_value = `SCSR_R_DIV_SEG_EN;
        `SCSR_A_FB_DIV_HIGH:      reset_value = `SCSR_R_FB_DIV_HIGH;
        `SCSR_A_FB_DIV_LOW:       reset_value = `SCSR_R_FB_DIV_LOW;
        `SCSR_A_DET_DELAY:        reset_value = `SCSR_R_DET_DELAY;
        `SCSR_A_FRAC_DEN_HIGH:    reset_value = `SCSR_R_FRAC_DEN;
        `SCSR_A_FRAC_DEN_LOW:     reset_value = `SCSR_R_FRAC_DEN;
        `SCSR_A_OUT_PWR_MOD:      reset_value = `SCSR_R_OUT_PWR_MOD;
        `SCSR_A_OUT_A_SEL:        reset_value = `SCSR_R_OUT_A_SEL;
        `SCSR_A_OUT_B_SEL:        reset_value = `SCSR_R_OUT_B_SEL;
        `SCSR_A_SYNC_PIN_IGNORE:  reset_value = `SCSR_R_SYNC_PIN_IGNORE;
        `SCSR_A_LOCK_TYPE:        reset_value = `SCSR_R_LOCK_TYPE;
        `SCSR_A_LOCK_DELAY:       reset_value = `SCSR_R_LOCK_DELAY;
        `SCSR_A_MOD_RST_CNT_LOW:  reset_value = `SCSR_R_MOD_RST_CNT_LOW;
        `SCSR_A_PULSE_GEN_CTRL:   reset_value = `SCSR_R_PULSE_GEN_CTRL;
        `SCSR_A_PULSE_RATE_DIV:   reset_value = `SCSR_R_PULSE_RATE_DIV;
        `SCSR_A_DELAY_WEIGHTS_12: reset_value = `SCSR_R_DELAY_WEIGHTS_12;
        `SCSR_A_DELAY_WEIGHTS_34: reset_value = `SCSR_R_DELAY_WEIGHTS_34;
        default:                  reset_value = `SCSR_R_ZERO;
      endcase
    end
  endfunction

  // Register storage, one word per address
  reg  [15:0] regs_q [0:`SCSR_NUM_REGS-1];

  reg                          sclk_prev_q;
  reg                          cs_prev_q;
  reg  [`SCSR_FRAME_BITS-1:0]  frame_q;
  reg  [`SCSR_FRAME_CNT_W-1:0] bit_cnt_q;
  reg  [15:0]                  read_shift_q;
  reg                          read_act_q;
  reg                          phase_sync_prev_q;
  reg                          req_meta_q;
  reg                          req_sync_q;
  reg  [1:0]                   prediv_cnt_q;
  reg  [11:0]                  half_cnt_q;
  reg  [3:0]                   pulse_cnt_q;
  reg                          req_tick_q;
  integer                      i;

  wire [15:0] main_ctrl   = regs_q[`SCSR_A_MAIN_CONTROL];
  wire [15:0] gen_ctrl    = regs_q[`SCSR_A_PULSE_GEN_CTRL];
  wire [15:0] rate_reg    = regs_q[`SCSR_A_PULSE_RATE_DIV];
  wire [15:0] weights_34  = regs_q[`SCSR_A_DELAY_WEIGHTS_34];
  wire        soft_rst    = main_ctrl[`SCSR_F_SOFT_RESET] & ~main_ctrl[`SCSR_F_POWER_OFF];
  wire        sclk_rise   = sclk & ~sclk_prev_q;
  wire        sclk_fall   = ~sclk & sclk_prev_q;
  wire        cs_rise     = cs_n & ~cs_prev_q;
  wire [`SCSR_FRAME_BITS-1:0] frame_next = {frame_q[`SCSR_FRAME_BITS-2:0], sdi};
  wire [6:0]  frame_addr  = frame_q[`SCSR_ADDR_HI:`SCSR_ADDR_LO];
  wire        frame_write = cs_rise && (bit_cnt_q == `SCSR_FRAME_DONE) &&
                            (frame_q[`SCSR_RW_BIT] == `SCSR_RW_WRITE) &&
                            (frame_addr <= `SCSR_LAST_ADDR);
  // At the eighth bit the address sits in the low bits of the shifted frame
  wire [6:0]  rd_addr     = frame_next[`SCSR_ADDR_HI-`SCSR_ADDR_LO:0];
  wire [15:0] rd_word     = (rd_addr <= `SCSR_LAST_ADDR) ? regs_q[rd_addr] : `SCSR_R_ZERO;

  // Generator fields
  wire [2:0]  prediv      = gen_ctrl[`SCSR_F_PREDIV_HI:`SCSR_F_PREDIV_LO];
  wire        burst_sel   = gen_ctrl[`SCSR_F_BURST_SELECT];
  wire        gen_enable  = gen_ctrl[`SCSR_F_PULSE_GEN_ENABLE];
  wire        repeat_sel  = gen_ctrl[`SCSR_F_REPEAT_SELECT];
  wire [3:0]  burst_count = weights_34[`SCSR_F_BURST_CNT_HI:`SCSR_F_BURST_CNT_LO];
  wire [11:0] rate_ratio  = `SCSR_RATE_BASE + {rate_reg[`SCSR_F_RATE_DIV_HI:0], 1'b0};
  wire        prediv_ok   = (prediv == `SCSR_PREDIV_1) || (prediv == `SCSR_PREDIV_2) ||
                            (prediv == `SCSR_PREDIV_4);
  wire        mode_on     = main_ctrl[`SCSR_F_PHASE_SYNC] & gen_enable &
                            ~main_ctrl[`SCSR_F_POWER_OFF] & prediv_ok;
  wire [1:0]  prediv_top  = prediv[2] ? 2'h3 : (prediv[1] ? 2'h1 : 2'h0);
  wire        interp_tick = (prediv_cnt_q == prediv_top);
  wire        burst_done  = burst_sel && (pulse_cnt_q == burst_count);

  // Serial frame capture and readback
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_prev_q  <= 1'b0;
      cs_prev_q    <= 1'b1;
      frame_q      <= {`SCSR_FRAME_BITS{1'b0}};
      bit_cnt_q    <= {`SCSR_FRAME_CNT_W{1'b0}};
      read_shift_q <= 16'h0000;
      read_act_q   <= 1'b0;
      sdo          <= 1'b0;
    end else begin
      sclk_prev_q <= sclk;
      cs_prev_q   <= cs_n;
      if (cs_n) begin
        bit_cnt_q  <= {`SCSR_FRAME_CNT_W{1'b0}};
        read_act_q <= 1'b0;
        sdo        <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt_q != `SCSR_FRAME_DONE) begin
          frame_q   <= frame_next;
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if ((bit_cnt_q == `SCSR_ADDR_DONE - 1'b1) && (frame_next[7] == `SCSR_RW_READ)) begin
            read_shift_q <= rd_word;
            read_act_q   <= 1'b1;
          end
        end
        // Data goes out on falling edges so the host samples it on rising ones
        if (sclk_fall && read_act_q) begin
          sdo          <= read_shift_q[`SCSR_DATA_HI];
          read_shift_q <= {read_shift_q[14:0], 1'b0};
        end
      end
    end
  end

  // Register bank; soft reset holds everything but main control at reset
  always @(posedge clk_sys) begin
    if (!rstn) begin
      for (i = 0; i < `SCSR_NUM_REGS; i = i + 1) begin
        regs_q[i] <= reset_value(i[6:0]);
      end
    end else begin
      for (i = 1; i < `SCSR_NUM_REGS; i = i + 1) begin
        if (soft_rst) begin
          regs_q[i] <= reset_value(i[6:0]);
        end else if (frame_write && frame_addr == i[6:0]) begin
          regs_q[i] <= frame_q[`SCSR_DATA_HI:0];
        end
      end
      if (frame_write && frame_addr == `SCSR_A_MAIN_CONTROL) begin
        regs_q[0] <= frame_q[`SCSR_DATA_HI:0];
      end
    end
  end

  // Mode outputs and one-cycle event pulses
  always @(posedge clk_sys) begin
    if (!rstn) begin
      power_off         <= 1'b0;
      phase_sync_enable <= 1'b0;
      pulse_mode_active <= 1'b0;
      sync_pulse        <= 1'b0;
      vco_cal_trigger   <= 1'b0;
      phase_sync_prev_q <= 1'b0;
    end else begin
      power_off         <= main_ctrl[`SCSR_F_POWER_OFF];
      phase_sync_enable <= main_ctrl[`SCSR_F_PHASE_SYNC];
      pulse_mode_active <= mode_on;
      phase_sync_prev_q <= main_ctrl[`SCSR_F_PHASE_SYNC];
      sync_pulse        <= main_ctrl[`SCSR_F_PHASE_SYNC] & ~phase_sync_prev_q;
      vco_cal_trigger   <= frame_write && (frame_addr == `SCSR_A_MAIN_CONTROL) &&
                           frame_q[`SCSR_F_CAL_TRIGGER];
    end
  end

  // Request pin synchroniser
  always @(posedge clk_sys) begin
    if (!rstn) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= pulse_request_pin;
      req_sync_q <= req_meta_q;
    end
  end

  // Pulse generator on the interpolator tick
  always @(posedge clk_sys) begin
    if (!rstn || soft_rst || !mode_on) begin
      prediv_cnt_q <= 2'h0;
      half_cnt_q   <= 12'h000;
      pulse_cnt_q  <= 4'h0;
      req_tick_q   <= 1'b0;
      output_b     <= 1'b0;
    end else begin
      prediv_cnt_q <= interp_tick ? 2'h0 : prediv_cnt_q + 1'b1;
      if (interp_tick) begin
        if (!repeat_sel) begin
          // Master: request low stops and rearms the series
          if (!req_sync_q) begin
            half_cnt_q  <= 12'h000;
            pulse_cnt_q <= 4'h0;
            output_b    <= 1'b0;
          end else if (half_cnt_q == rate_ratio - 1'b1) begin
            half_cnt_q <= 12'h000;
            if (output_b) begin
              output_b <= 1'b0;
            end else if (!burst_done) begin
              output_b    <= 1'b1;
              pulse_cnt_q <= pulse_cnt_q + 1'b1;
            end
          end else begin
            half_cnt_q <= half_cnt_q + 1'b1;
          end
        end else begin
          // Repeater: echo the reclocked request, limited in burst mode
          req_tick_q <= req_sync_q;
          if (req_tick_q && !output_b) begin
            if (!burst_done) begin
              output_b    <= 1'b1;
              pulse_cnt_q <= pulse_cnt_q + 1'b1;
            end
          end else if (!req_tick_q) begin
            output_b <= 1'b0;
          end
        end
      end
    end
  end

endmodule // scsr_top

`default_nettype wire

// File: verif/scsr_chk_sva.sv
// Checker for the serial register bank and pulse generator outputs
`default_nettype none
module scsr_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic output_b,
  input wire logic power_off,
  input wire logic phase_sync_enable,
  input wire logic pulse_mode_active,
  input wire logic sync_pulse,
  input wire logic vco_cal_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q = 1'b0;
  logic [2:0] cs_age_q = 3'h7;
  logic [2:0] fall_age_q = 3'h7;
  // Cycles since select was last low and since the serial clock last fell
  always @(posedge clk_sys) begin
    sclk_q <= sclk;
    cs_age_q <= !cs_n ? 3'h0 : (cs_age_q == 3'h7 ? cs_age_q : cs_age_q + 3'h1);
    fall_age_q <= (sclk_q && !sclk) ? 3'h0 : (fall_age_q == 3'h7 ? fall_age_q : fall_age_q + 3'h1);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_cal_one_cycle: assert property (vco_cal_trigger |=> !vco_cal_trigger) else $error("cal trigger too long");
  a_cal_after_frame: assert property (vco_cal_trigger |-> cs_n && cs_age_q <= 3'h5) else $error("cal trigger unprompted");
  a_sdo_idle_low: assert property (cs_n && $past(cs_n) |-> !sdo) else $error("sdo active while idle");
  a_sdo_on_fall: assert property (!cs_n && $past(!cs_n) && $changed(sdo) |-> fall_age_q <= 3'h4) else $error("sdo moved off fall");
  a_sync_on_rise: assert property ($rose(phase_sync_enable) |-> ##[0:1] sync_pulse) else $error("no sync pulse");
  a_sync_one_cycle: assert property (sync_pulse |=> !sync_pulse) else $error("sync pulse too long");
  a_mode_needs_sync: assert property (pulse_mode_active |-> phase_sync_enable || $past(phase_sync_enable)) else $error("mode without sync");
  a_power_stops_gen: assert property (power_off && $past(power_off) |-> !pulse_mode_active) else $error("generator runs while off");
  a_outb_gated: assert property (!pulse_mode_active && !$past(pulse_mode_active) && !$past(pulse_mode_active, 2) |-> !output_b) else $error("output b active while off");
  c_cal: cover property (vco_cal_trigger);
  c_sync: cover property (sync_pulse);
  c_pulse: cover property ($rose(output_b) && pulse_mode_active);
endmodule // scsr_chk

bind scsr_top scsr_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
  .output_b(output_b), .power_off(power_off), .phase_sync_enable(phase_sync_enable),
  .pulse_mode_active(pulse_mode_active), .sync_pulse(sync_pulse), .vco_cal_trigger(vco_cal_trigger));
`default_nettype wire

// File: verif/scsr_host.sv
// Host model that drives programming frames on the serial port
`default_nettype none
module scsr_host (
  input  wire logic clk_sys,
  input  wire logic sdo,
  output var logic  sclk,
  output var logic  sdi,
  output var logic  cs_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end
  // Sends the top nb bits of f, each phase of sclk held three cycles
  task automatic xfer(input logic [23:0] f, input int nb, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      sdi <= f[i];
      repeat (3) @(posedge clk_sys);
      if (i < 16) rd[i] = sdo;
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clk_sys);
    cs_n <= 1'b1;
    // Released data line shows no stale value
    sdi <= ~sdi;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule // scsr_host
`default_nettype wire

// File: verif/scsr_top_test.sv
// Self-checking bench for the serial register bank and pulse generator
`default_nettype none
module scsr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic pulse_request_pin = 1'b0;
  wire logic sclk, sdi, cs_n, sdo, output_b, power_off, phase_sync_enable, pulse_mode_active, sync_pulse, vco_cal_trigger;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 37695;
  int rises = 0;
  int cals = 0;
  int syncs = 0;
  int h;
  logic ob_q = 1'b0;
  logic [15:0] mem [0:127];
  logic [15:0] r;
  logic [6:0] ra [8] = '{7'h00, 7'h2e, 7'h47, 7'h48, 7'h49, 7'h4a, 7'h50, 7'h7f};
  always #25 clk_sys = ~clk_sys;
  scsr_top uut (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .pulse_request_pin(pulse_request_pin), .sdo(sdo), .output_b(output_b), .power_off(power_off),
    .phase_sync_enable(phase_sync_enable), .pulse_mode_active(pulse_mode_active),
    .sync_pulse(sync_pulse), .vco_cal_trigger(vco_cal_trigger));
  scsr_host host (.clk_sys(clk_sys), .sdo(sdo), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));
  function automatic logic [15:0] rv(input logic [6:0] x);
    case (x)
      7'h00: return 16'h200c;
      7'h2e: return 16'h07f0;
      7'h47: return 16'h0080;
      7'h48: return 16'h0001;
      7'h49: return 16'h003f;
      7'h4a: return 16'h4000;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] aw, input logic [15:0] dw);
    host.xfer({1'b0, aw, dw}, 24, r);
    if (aw <= 7'h72 && (aw == 7'h00 || mem[0][1:0] != 2'b10)) mem[aw] = dw;
    if (aw == 7'h00 && dw[1:0] == 2'b10) for (int i = 1; i < 128; i++) mem[i] = rv(i[6:0]);
  endtask
  task automatic rd(input logic [6:0] ar, input string what);
    host.xfer({1'b1, ar, 16'h0000}, 24, r);
    check(r, mem[ar], what);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(negedge clk_sys) begin
    if (output_b === 1'b1 && ob_q !== 1'b1) rises++;
    ob_q = output_b;
    if (vco_cal_trigger === 1'b1) cals++;
    if (sync_pulse === 1'b1) syncs++;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 25000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = rv(i[6:0]);
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (ra[i]) rd(ra[i], "reset value");
    repeat (12) begin
      h = $random(seed);
      wr({1'b0, h[5:0]} + 7'h01, h[31:16]);
      rd({1'b0, h[5:0]} + 7'h01, "random register");
    end
    wr(7'h7f, 16'h1234);
    rd(7'h7f, "unmapped");
    host.xfer({1'b0, 7'h48, 16'h0abc}, 23, r);
    rd(7'h48, "short frame");
    wr(7'h00, 16'h4008);
    @(negedge clk_sys);
    check({14'h0000, phase_sync_enable, power_off}, 16'h0002, "sync pin");
    check(16'(cals), 16'h0001, "cal trigger pulses");
    check(16'(syncs), 16'h0001, "sync pulses");
    wr(7'h00, 16'h4009);
    @(negedge clk_sys);
    check({14'h0000, phase_sync_enable, power_off}, 16'h0003, "power pin");
    wr(7'h00, 16'h4000);
    wr(7'h2e, 16'h07f2);
    wr(7'h49, 16'h0fc0);
    wr(7'h48, 16'h0001);
    pulse_request_pin <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(7'h47, 16'h0008 | (16'h0020 << k));
      repeat (2) begin
        h = 0;
        while (output_b !== 1'b1 && h < 400) begin @(negedge clk_sys); h++; end
        h = 0;
        while (output_b === 1'b1 && h < 400) begin @(negedge clk_sys); h++; end
      end
      check({15'h0000, pulse_mode_active}, 16'h0001, "mode active");
      check(16'(h), 16'(6 << k), "high time");
    end
    wr(7'h47, 16'h0068);
    check({15'h0000, pulse_mode_active}, 16'h0000, "bad prediv");
    wr(7'h4a, 16'h3000);
    pulse_request_pin <= 1'b0;
    wr(7'h47, 16'h0038);
    h = rises;
    pulse_request_pin <= 1'b1;
    repeat (300) @(posedge clk_sys);
    check(16'(rises - h), 16'h0003, "burst pulses");
    pulse_request_pin <= 1'b0;
    wr(7'h47, 16'h002c);
    h = rises;
    repeat (8) begin
      repeat (10) @(posedge clk_sys);
      pulse_request_pin <= ~pulse_request_pin;
    end
    repeat (10) @(posedge clk_sys);
    check(16'(rises - h), 16'h0004, "repeated pulses");
    wr(7'h00, 16'h4002);
    rd(7'h4a, "soft reset hold");
    wr(7'h4a, 16'h5000);
    rd(7'h4a, "write during soft reset");
    wr(7'h00, 16'h4000);
    wr(7'h4a, 16'h5000);
    rd(7'h4a, "after release");
    tally_and_finish();
  end
endmodule // scsr_top_test
`default_nettype wire
